/* hdl/ssc_pkg.sv */
// Constants, types and register map of the status nibble and slow channel block.
// Assumes a SENT frame framer on the same clock that pulses a frame start.
// What this block does
// RQ1: By default the frame CRC leaves the status nibble out.
// RQ2: With crcCoversNibble set the status nibble enters the frame CRC.
// RQ3: Hard flag latches for good on watchdog, memory, self-test or odd reset.
// RQ4: Hard flag also shows while idle or in reset, clearing afterwards.
// RQ5: Soft flag sets on unmasked error or idle, clears next frame otherwise.
// RQ6: Die id bit 0 follows idPinLow, bit 1 follows idPinHigh.
// RQ7: Select values 000 to 011 choose the first four nibble layouts.
// RQ8: Select values 100 to 111 choose the last four nibble layouts.
// RQ9: Sixteen-bit packet, one bit per frame, MSB first, sync in first frame.
// RQ10: Packet is message id, then eight data bits, then four CRC bits.
// RQ11: Packet CRC covers id and data with the frame CRC algorithm.
// RQ12: Message id steps through sixteen values, one per packet.
// RQ13: Ids 0 and 8 carry the alive counter, bumped per full rotation.
// RQ14: Ids 1 and 9 carry temperature plus 64.
// RQ15: Ids 2 and 10 carry field in gauss divided by 8.
// RQ16: Ids 3-5 and 11-13 carry status word bytes high to low.
// RQ17: Ids 6/14 and 7/15 carry the two customer bytes.
// RQ18: Angle fills the first three data nibbles; up to six per setting.
// RQ19: crcCoversNibble sits in bit 15 of the configuration word.
// RQ20: Nibble content select sits in bits 14 to 12 of the configuration word.
// RQ21: Combined error bit is soft OR hard.
// RQ22: Each packet's data byte is frozen when its packet starts.
package ssc_pkg;
	localparam logic [11:0] ADDR_CFG = 12'h000;
	localparam logic [11:0] ADDR_NVW_A = 12'h004;
	localparam logic [11:0] ADDR_NVW_B = 12'h008;
	localparam logic [11:0] ADDR_STAT = 12'h00C;
	localparam int CFG_COVER_BIT = 15;
	localparam int CFG_SEL_LSB = 12;
	localparam int NVW_HI_LSB = 20;
	localparam int NVW_B_LSB = 12;
	localparam logic [15:0] CFG_RESET = 16'h0003;
	localparam logic [3:0] CRC_SEED = 4'h5;
	localparam logic [3:0] CRC_POLY = 4'hD;
	localparam logic [7:0] TEMP_OFFSET = 8'h40;
	localparam logic [3:0] PKT_LAST = 4'hF;
	localparam logic [2:0] NIB_MIN = 3'h3;
	localparam logic [2:0] NIB_MAX = 3'h6;
	typedef enum logic [2:0] {
		SEL_FLAGS = 3'b000, SEL_SER_FLAGS = 3'b001, SEL_ID_FLAGS = 3'b010,
		SEL_COMB = 3'b011, SEL_ID = 3'b100, SEL_SER_ID = 3'b101,
		SEL_FLAGS_ID = 3'b110, SEL_SER_COMB = 3'b111
	} ssc_sel_t;
	typedef struct packed {
		logic watchdog;
		logic nvmMultiBit;
		logic ramHard;
		logic selfTest;
		logic otherReset;
	} ssc_hard_ev_t;
	typedef struct packed {
		logic [3:0] statusNibble;
		logic [23:0] dataNibbles;
		logic [2:0] nibbleCount;
		logic [3:0] frameCrc;
		logic slowSyncBit;
		logic slowDataBit;
	} ssc_frame_t;
endpackage

/* hdl/ssc_status_nibble.sv */
// Status nibble, slow channel packet and frame CRC for each SENT frame.
// Assumes frameStart is a one-cycle pulse from the framer on clk; pins are async.
//
// The placing of the registers and the APB register port were chosen for this implementation.
`default_nettype none
module ssc_status_nibble (
	input wire logic clk, // 25 MHz core clock
	input wire logic rst_b, // Sync reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic frameStart, // One-cycle pulse, new frame
	input wire logic [11:0] angle, // Angle code
	input wire logic [11:0] extraData, // Nibbles 4 to 6
	input wire ssc_pkg::ssc_hard_ev_t hardEvents, // Latching hard causes
	input wire logic procIdle, // Processor not producing angles
	input wire logic inReset, // Power-on, hard or soft reset
	input wire logic softError, // Any unmasked error
	input wire logic [7:0] temperature, // Degrees Celsius, signed
	input wire logic [10:0] fieldGauss, // Field in gauss
	input wire logic [23:0] statusWord, // Status flags
	input wire logic idPinLow, // Address pin, async
	input wire logic idPinHigh, // Address pin, async
	output ssc_pkg::ssc_frame_t frameOut // Frame content, per frame
);
	logic [15:0] cfg_q;
	logic [3:0] nvwA_q;
	logic [11:0] nvwB_q;
	logic [1:0] idMeta_q;
	logic [1:0] idSync_q;
	logic hardLatch_q;
	logic softPend_q;
	logic [3:0] bitIdx_q;
	logic [3:0] msgId_q;
	logic [7:0] alive_q;
	logic [15:0] packet_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	ssc_pkg::ssc_frame_t frame_q;

	function automatic logic [3:0] crcMul(input logic [3:0] c);
		logic [3:0] r;
		r = c;
		for (int i = 0; i < 4; i++)
		begin
			r = r[3] ? ({r[2:0], 1'b0} ^ ssc_pkg::CRC_POLY) : {r[2:0], 1'b0};
		end
		return r;
	endfunction

	// Top cnt nibbles of v, then one zero nibble to flush
	function automatic logic [3:0] crcNibbles(input logic [27:0] v, input logic [2:0] cnt);
		logic [3:0] c;
		c = ssc_pkg::CRC_SEED;
		for (int i = 0; i < 7; i++)
		begin
			if (3'(i) < cnt)
				c = crcMul(c) ^ v[27 - 4 * i -: 4];
		end
		return crcMul(c);
	endfunction

	// APB decode
	wire setupPhase = psel & ~penable;
	wire accessDone = psel & penable & pready_q;
	wire hitCfg = (paddr == ssc_pkg::ADDR_CFG);
	wire hitNvwA = (paddr == ssc_pkg::ADDR_NVW_A);
	wire hitNvwB = (paddr == ssc_pkg::ADDR_NVW_B);
	wire hitStat = (paddr == ssc_pkg::ADDR_STAT);
	wire hitAny = hitCfg | hitNvwA | hitNvwB | hitStat;
	// Status is read only, writing it is an error
	wire badAccess = ~hitAny | (pwrite & hitStat);
	wire wrCfg = accessDone & pwrite & hitCfg;
	wire wrNvwA = accessDone & pwrite & hitNvwA;
	wire wrNvwB = accessDone & pwrite & hitNvwB;

	// Configuration fields
	// RQ19 cover bit
	wire crcCoversNibble = cfg_q[ssc_pkg::CFG_COVER_BIT];
	// RQ20 select field
	wire [2:0] nibbleContentSelect = cfg_q[ssc_pkg::CFG_SEL_LSB +: 3];
	// RQ18 clamp count
	wire [2:0] nibbleCountRaw = cfg_q[2:0];
	wire [2:0] nibbleCount = (nibbleCountRaw < ssc_pkg::NIB_MIN) ? ssc_pkg::NIB_MIN :
		(nibbleCountRaw > ssc_pkg::NIB_MAX) ? ssc_pkg::NIB_MAX : nibbleCountRaw;

	// Error flags
	// RQ3 latch causes
	wire hardCause = |hardEvents;
	// RQ4 temporary causes
	wire hardFlag = hardLatch_q | hardCause | procIdle | inReset;
	// RQ5 soft cause
	wire softCause = softError | procIdle;
	wire softFlag = softPend_q | softCause;
	// RQ21 combined error
	wire combErr = softFlag | hardFlag;
	// RQ6 die id bits
	wire dieIdBit0 = idSync_q[0];
	wire dieIdBit1 = idSync_q[1];

	// Slow channel packet
	wire packetStart = (bitIdx_q == 4'h0);
	wire [2:0] msgSlot = msgId_q[2:0];
	logic [7:0] slowByte;
	always_comb
	begin
		slowByte = 8'h00;
		case (msgSlot)
			// RQ13 alive counter
			3'h0: slowByte = alive_q;
			// RQ14 temperature offset
			3'h1: slowByte = temperature + ssc_pkg::TEMP_OFFSET;
			// RQ15 field scaled
			3'h2: slowByte = fieldGauss[10:3];
			// RQ16 status bytes
			3'h3: slowByte = statusWord[23:16];
			3'h4: slowByte = statusWord[15:8];
			3'h5: slowByte = statusWord[7:0];
			// RQ17 customer bytes
			3'h6: slowByte = {nvwA_q, nvwB_q[11:8]};
			3'h7: slowByte = nvwB_q[7:0];
			default: slowByte = 8'h00;
		endcase
	end
	// RQ11 packet CRC
	wire [3:0] packetCrc = crcNibbles({msgId_q, slowByte, 16'h0000}, 3'h3);
	// RQ10 packet layout
	wire [15:0] freshPacket = {msgId_q, slowByte, packetCrc};
	// RQ22 frozen byte
	wire [15:0] livePacket = packetStart ? freshPacket : packet_q;
	// RQ9 MSB first
	wire slowDataBit = livePacket[4'hF - bitIdx_q];
	wire slowSyncBit = packetStart;

	// Nibble selection
	logic [3:0] statusNibble;
	always_comb
	begin
		statusNibble = 4'h0;
		case (ssc_pkg::ssc_sel_t'(nibbleContentSelect))
			// RQ7 first layouts
			ssc_pkg::SEL_FLAGS: statusNibble = {2'b00, softFlag, hardFlag};
			ssc_pkg::SEL_SER_FLAGS: statusNibble = {slowSyncBit, slowDataBit, softFlag, hardFlag};
			ssc_pkg::SEL_ID_FLAGS: statusNibble = {dieIdBit1, dieIdBit0, softFlag, hardFlag};
			ssc_pkg::SEL_COMB: statusNibble = {3'b000, combErr};
			// RQ8 last layouts
			ssc_pkg::SEL_ID: statusNibble = {2'b00, dieIdBit1, dieIdBit0};
			ssc_pkg::SEL_SER_ID: statusNibble = {slowSyncBit, slowDataBit, dieIdBit1, dieIdBit0};
			ssc_pkg::SEL_FLAGS_ID: statusNibble = {softFlag, hardFlag, dieIdBit1, dieIdBit0};
			ssc_pkg::SEL_SER_COMB: statusNibble = {slowSyncBit, slowDataBit, 1'b0, combErr};
			default: statusNibble = 4'h0;
		endcase
	end

	// Frame data and CRC
	// RQ18 angle first
	wire [23:0] dataNibbles = {angle, extraData};
	// RQ1 nibble excluded
	wire [3:0] crcPlain = crcNibbles({dataNibbles, 4'h0}, nibbleCount);
	// RQ2 nibble included
	wire [3:0] crcCover = crcNibbles({statusNibble, dataNibbles}, 3'(nibbleCount + 3'h1));
	wire [3:0] frameCrc = crcCoversNibble ? crcCover : crcPlain;
	ssc_pkg::ssc_frame_t frame_d;
	assign frame_d = '{statusNibble: statusNibble, dataNibbles: dataNibbles, nibbleCount: nibbleCount,
		frameCrc: frameCrc, slowSyncBit: slowSyncBit, slowDataBit: slowDataBit};

	// Read mux
	wire [31:0] statWord = {8'h00, alive_q, msgId_q, bitIdx_q, 5'h00, hardLatch_q, softFlag, hardFlag};
	wire [31:0] rdMux = hitCfg ? {16'h0000, cfg_q} :
		hitNvwA ? {8'h00, nvwA_q, 20'h00000} :
		hitNvwB ? {8'h00, nvwB_q, 12'h000} :
		hitStat ? statWord : 32'h00000000;

	// Pins pass two flops before use
	always_ff @(posedge clk)
	begin
		idMeta_q <= {idPinHigh, idPinLow};
		idSync_q <= idMeta_q;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end
		else
		begin
			// One wait-free access phase per setup
			pready_q <= setupPhase;
			pslverr_q <= setupPhase & badAccess;
			prdata_q <= (setupPhase & ~pwrite) ? rdMux : 32'h00000000;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			cfg_q <= ssc_pkg::CFG_RESET;
			nvwA_q <= 4'h0;
			nvwB_q <= 12'h000;
		end
		else
		begin
			if (wrCfg)
				cfg_q <= pwdata[15:0];
			if (wrNvwA)
				nvwA_q <= pwdata[ssc_pkg::NVW_HI_LSB +: 4];
			if (wrNvwB)
				nvwB_q <= pwdata[ssc_pkg::NVW_B_LSB +: 12];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			hardLatch_q <= 1'b0;
		// RQ3 permanent latch
		else if (hardCause)
			hardLatch_q <= 1'b1;
	end

	// Cause in the clearing cycle keeps the flag
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			softPend_q <= 1'b0;
		// RQ5 clear per frame
		else
			softPend_q <= (softPend_q & ~frameStart) | softCause;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			bitIdx_q <= 4'h0;
			msgId_q <= 4'h0;
			alive_q <= 8'h00;
			packet_q <= 16'h0000;
		end
		else if (frameStart)
		begin
			bitIdx_q <= bitIdx_q + 4'h1;
			if (packetStart)
				packet_q <= freshPacket;
			// RQ12 id per packet
			if (bitIdx_q == ssc_pkg::PKT_LAST)
				msgId_q <= msgId_q + 4'h1;
			// RQ13 bump on rotation
			if (bitIdx_q == ssc_pkg::PKT_LAST && msgId_q == ssc_pkg::PKT_LAST)
				alive_q <= alive_q + 8'h01;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			frame_q <= '0;
		else if (frameStart)
			frame_q <= frame_d;
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign frameOut = frame_q;
endmodule // ssc_status_nibble
`default_nettype wire

/* test/ssc_monitor.sv */
// Port checker for the status nibble block.
// Assumes it is bound to every instance of the block.
`default_nettype none
module ssc_monitor (
	input wire logic clk, // Clock
	input wire logic rst_b, // Reset
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pready, // APB ready
	input wire logic pslverr, // APB error
	input wire logic [31:0] prdata, // Read data
	input wire logic frameStart, // Frame pulse
	input wire logic [11:0] angle, // Angle
	input wire ssc_pkg::ssc_hard_ev_t hardEvents, // Hard causes
	input wire ssc_pkg::ssc_frame_t frameOut // Frame content
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	setup_ready_a: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	ready_cause_a: assert property (pready |-> $past(psel) && !$past(penable))
		else $error("ready without setup");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	frame_hold_a: assert property (!frameStart |=> $stable(frameOut))
		else $error("frame changed between starts");
	angle_place_a: assert property (frameStart |=> frameOut.dataNibbles[23:12] == $past(angle))
		else $error("angle not in first nibbles");
	nib_count_a: assert property (frameStart |=> frameOut.nibbleCount inside {[3:6]})
		else $error("nibble count out of range");
	sync_once_a: assert property (frameStart && frameOut.slowSyncBit |=> !frameOut.slowSyncBit)
		else $error("sync in two frames running");
	reset_clear_a: assert property (disable iff (1'b0) !rst_b |=> frameOut == '0 && !pready)
		else $error("reset left outputs set");
	cover property (frameStart && frameOut.slowSyncBit);
	cover property (pready && pslverr);
	cover property (|hardEvents);
endmodule // ssc_monitor
bind ssc_status_nibble ssc_monitor mon (.clk, .rst_b, .psel, .penable, .pready, .pslverr, .prdata,
	.frameStart, .angle, .hardEvents, .frameOut);
`default_nettype wire

/* test/ssc_host_model.sv */
// Host side decoder of the slow channel bits of each frame.
// Assumes frameOut settles one cycle after the frame pulse.
`default_nettype none
module ssc_host_model (
	input wire logic clk, // Clock
	input wire logic rst_b, // Reset
	input wire logic frameStart, // Frame pulse
	input wire ssc_pkg::ssc_frame_t frameOut, // Frame content
	output logic [15:0] packet, // Last whole packet
	output logic [7:0] pktCount // Packets decoded
);
	timeunit 1ns;
	timeprecision 1ns;
	logic seen;
	logic [15:0] sh;
	int n;
	always @(posedge clk)
	begin
		seen <= frameStart && rst_b;
		if (!rst_b)
		begin
			n = 0;
			pktCount <= 8'h0;
		end
		else if (seen)
		begin
			n = frameOut.slowSyncBit ? 1 : n + 1;
			sh = {sh[14:0], frameOut.slowDataBit};
			if (n == 16)
			begin
				packet <= sh;
				pktCount <= pktCount + 8'h1;
			end
		end
	end
endmodule // ssc_host_model
`default_nettype wire

/* test/ssc_status_nibble_test.sv */
// Self-checking bench for the status nibble block.
// Assumes the host model and the bound port checker.
`default_nettype none
module ssc_status_nibble_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_b, psel, penable, pwrite, pready, pslverr, frameStart, er;
	logic procIdle, inReset, softError, idPinLow, idPinHigh;
	logic [11:0] paddr, angle, extraData;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] temperature, pktCount;
	logic [10:0] fieldGauss;
	logic [23:0] statusWord;
	logic [15:0] packet;
	ssc_pkg::ssc_hard_ev_t hardEvents;
	ssc_pkg::ssc_frame_t frameOut;
	int fail_count, cmp_count, cyc;
	// Slot bytes for the stimulus below; slot 0 is the alive count
	logic [7:0] tbl [8] = '{8'h0, 8'h20, 8'hB5, 8'h12, 8'h34, 8'h56, 8'hA5, 8'hC3};
	ssc_status_nibble dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .frameStart, .angle, .extraData, .hardEvents, .procIdle, .inReset, .softError,
		.temperature, .fieldGauss, .statusWord, .idPinLow, .idPinHigh, .frameOut);
	ssc_host_model host (.clk, .rst_b, .frameStart, .frameOut, .packet, .pktCount);
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask
	task automatic frame();
		frameStart <= 1'h1;
		@(posedge clk);
		frameStart <= 1'h0;
		repeat (3) @(posedge clk);
	endtask
	task automatic reset();
		rst_b <= 1'h0;
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		@(posedge clk);
	endtask
	function automatic logic [3:0] crc4(input logic [27:0] v, input int n);
		logic [3:0] c;
		logic f;
		c = ssc_pkg::CRC_SEED;
		// Trailing zero nibble as augmentation
		for (int i = 4 * n - 1; i >= -4; i--)
		begin
			f = c[3];
			c = {c[2:0], i >= 0 ? v[i] : 1'h0};
			if (f)
				c = c ^ ssc_pkg::CRC_POLY;
		end
		return c;
	endfunction
	function automatic logic [3:0] nib(input int s, input logic sy, da, so, ha, i1, i0);
		case (s)
			0: return {2'h0, so, ha};
			1: return {sy, da, so, ha};
			2: return {i1, i0, so, ha};
			3: return {3'h0, so | ha};
			4: return {2'h0, i1, i0};
			5: return {sy, da, i1, i0};
			6: return {so, ha, i1, i0};
			default: return {sy, da, 1'h0, so | ha};
		endcase
	endfunction
	task automatic t_regs();
		apb(1'h0, ssc_pkg::ADDR_CFG, 32'h0);
		chk(rd, 32'(ssc_pkg::CFG_RESET));
		apb(1'h1, ssc_pkg::ADDR_CFG, 32'hF004);
		apb(1'h0, ssc_pkg::ADDR_CFG, 32'h0);
		chk(rd, 32'hF004);
		chk(32'(er), 32'h0);
		apb(1'h1, ssc_pkg::ADDR_STAT, 32'hFFFF);
		chk(32'(er), 32'h1);
		apb(1'h0, 12'h010, 32'h0);
		chk(32'(er), 32'h1);
		chk(rd, 32'h0);
		$display("regs done, %0d bad", fail_count);
	endtask
	task automatic t_modes();
		logic [3:0] e;
		softError <= 1'h1;
		for (int s = 0; s < 8; s++)
			for (int i = 0; i < 4; i++)
			begin
				{idPinHigh, idPinLow} <= 2'(i);
				angle <= 12'(s * 300 + i * 77 + 5);
				apb(1'h1, ssc_pkg::ADDR_CFG, 32'({s[1], 3'(s), 12'h003}));
				frame();
				e = nib(s, frameOut.slowSyncBit, frameOut.slowDataBit, 1'h1, 1'h0, i[1], i[0]);
				chk(32'(frameOut.statusNibble), 32'(e));
				chk(32'(frameOut.frameCrc), 32'(crc4(s[1] ? {4'h0, e, angle} : 20'(angle), s[1] ? 4 : 3)));
			end
		// Count above six clamps to six, below three to three
		apb(1'h1, ssc_pkg::ADDR_CFG, 32'h0007);
		frame();
		chk(32'(frameOut.nibbleCount), 32'h6);
		chk(32'(frameOut.dataNibbles), {8'h00, angle, extraData});
		chk(32'(frameOut.frameCrc), 32'(crc4({4'h0, angle, extraData}, 6)));
		apb(1'h1, ssc_pkg::ADDR_CFG, 32'h0001);
		frame();
		chk(32'(frameOut.nibbleCount), 32'h3);
		$display("modes done, %0d bad", fail_count);
	endtask
	task automatic t_flags();
		softError <= 1'h0;
		reset();
		procIdle <= 1'h1;
		frame();
		chk(32'(frameOut.statusNibble), 32'h3);
		procIdle <= 1'h0;
		frame();
		frame();
		chk(32'(frameOut.statusNibble), 32'h0);
		softError <= 1'h1;
		@(posedge clk);
		softError <= 1'h0;
		frame();
		chk(32'(frameOut.statusNibble), 32'h2);
		frame();
		chk(32'(frameOut.statusNibble), 32'h0);
		inReset <= 1'h1;
		frame();
		chk(32'(frameOut.statusNibble), 32'h1);
		inReset <= 1'h0;
		frame();
		chk(32'(frameOut.statusNibble), 32'h0);
		for (int k = 0; k < 5; k++)
		begin
			reset();
			hardEvents <= 5'(1 << k);
			@(posedge clk);
			hardEvents <= 5'h0;
			frame();
			frame();
			chk(32'(frameOut.statusNibble), 32'h1);
		end
		// Hard only, so a soft-only combined bit would show zero
		apb(1'h1, ssc_pkg::ADDR_CFG, 32'h3003);
		frame();
		chk(32'(frameOut.statusNibble), 32'h1);
		$display("flags done, %0d bad", fail_count);
	endtask
	task automatic t_slow();
		logic [7:0] n;
		reset();
		temperature <= 8'hE0;
		fieldGauss <= 11'h5A8;
		statusWord <= 24'h123456;
		apb(1'h1, ssc_pkg::ADDR_NVW_A, 32'h00A00000);
		apb(1'h1, ssc_pkg::ADDR_NVW_B, 32'h005C3000);
		apb(1'h1, ssc_pkg::ADDR_CFG, 32'h1003);
		n = pktCount;
		for (int k = 0; k < 272; k++)
		begin
			frame();
			// Disturb the status word inside each packet, restore before the next start
			statusWord <= (k % 16 == 15) ? 24'h123456 : 24'hEDCBA9;
			chk(32'(frameOut.statusNibble[3:2]), 32'({frameOut.slowSyncBit, frameOut.slowDataBit}));
			if (pktCount != n)
			begin
				n = pktCount;
				chk(32'(packet[15:12]), 32'((n - 8'h1) & 8'hF));
				chk(32'(packet[11:4]), 32'(packet[14:12] == 3'h0 ? (n - 8'h1) >> 4 : tbl[packet[14:12]]));
				chk(32'(packet[3:0]), 32'(crc4(20'(packet[15:4]), 3)));
			end
		end
		chk(32'(pktCount), 32'd17);
		$display("slow done, %0d bad", fail_count);
	endtask
	initial
	begin
		{psel, penable, pwrite, frameStart, procIdle, inReset, softError, idPinLow, idPinHigh} = '0;
		paddr = '0;
		pwdata = '0;
		angle = '0;
		extraData = 12'hABC;
		temperature = '0;
		fieldGauss = '0;
		statusWord = '0;
		hardEvents = '0;
		rst_b = 1'b0;
		repeat (16) @(posedge clk);
		rst_b <= 1'h1;
		@(posedge clk);
		t_regs();
		t_modes();
		t_flags();
		t_slow();
		summarize();
	end
endmodule // ssc_status_nibble_test
`default_nettype wire
